// ==== rtl/card_reader_pkg.sv ====
// Constants, field positions and types for the card reader command controller
// Function
// RULE_01: Respond only when command word bits 7-10 equal the four jumpered equipment bits.
// RULE_02: Host drives command word bits 11-15 to zero when addressing this controller.
// RULE_03: Decode only command bits 0 and 1; ignore 2-5; host keeps bit 6 zero.
// RULE_04: Legal codes: read data, status one, status two; write function, test; others rejected.
// RULE_05: With protect jumper in, unprotected instructions are rejected; status reads never are.
// RULE_06: Function bit 0 clears control, interrupts and alarms; other bits override it.
// RULE_07: Function bit 1 clears interrupts; enables in the same word still take effect.
// RULE_08: Function bit 2 enables data interrupt; cleared by clears unless rewritten as one.
// RULE_09: A data transfer drops the data interrupt until the next column is ready.
// RULE_10: Bit 3 enables end-of-operation interrupt, only for operations ending after enabling.
// RULE_11: Bit 4 enables alarm interrupt, answering at once for an existing alarm.
// RULE_12: Bit 6 sets auto-transfer mode until master clear or a function without bit 6.
// RULE_13: Bit 7 feeds one card; a second feed restarts without end of operation.
// RULE_14: Several function bits in one word execute together as one operation.
// RULE_15: While not ready, a function is refused if bits 2,3,4,6 or 7 are set.
// RULE_16: Status one always answers with ready, busy, interrupt, data, alarms, protect, mode.
// RULE_17: Not-ready is the inverse of ready; ready needs supplies, hopper, stacker, no faults.
// RULE_18: Status bit 2 shows a common interrupt; bits 3-5 name its source.
// RULE_19: Data status is set while a column waits and drops when it is taken.
// RULE_20: End of operation sets at column 81 or lost data; clears on feed or clears.
// RULE_21: Alarm from lost data or malfunction clears on clears or feed once cause gone.
// RULE_22: Lost data sets on an untaken column; transfers refused until end of operation; the code keeps refusing them until a clear (bit 0) or a feed.
// RULE_23: A data transfer returns the last column on data bits 0-11.
// RULE_24: Common interrupt is the OR of data, end-of-operation and alarm responses.
// RULE_25: Auto-transfer interrupt needs the mode and data response, with no other response.
// RULE_26: Status two always answers; bit 0 reports hopper empty with last card read.
package card_reader_pkg;
    localparam int WORD_W = 16;
    localparam int COL_W = 12;
    localparam int EQ_W = 4;
    localparam int EQ_LSB = 7;
    localparam int EQ_MSB = 10;
    localparam int CODE_LSB = 0;
    localparam int CODE_MSB = 1;
    localparam logic [1:0] CODE_DATA = 2'h0;
    localparam logic [1:0] CODE_ST1 = 2'h1;
    localparam logic [1:0] CODE_TEST = 2'h2;
    localparam logic [1:0] CODE_ST2 = 2'h3;
    // Director function bits
    localparam int FN_CLEAR = 0;
    localparam int FN_CLR_INT = 1;
    localparam int FN_DATA_IE = 2;
    localparam int FN_EOP_IE = 3;
    localparam int FN_ALARM_IE = 4;
    localparam int FN_ADT = 6;
    localparam int FN_FEED = 7;
    localparam int TEST_ON = 0;
    localparam logic [WORD_W-1:0] FN_NOT_READY_MASK = 16'h00dc;
    // Status one and status two bits
    localparam int ST_READY = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_INT = 2;
    localparam int ST_DATA = 3;
    localparam int ST_EOP = 4;
    localparam int ST_ALARM = 5;
    localparam int ST_LOST = 6;
    localparam int ST_PROT = 7;
    localparam int ST_NREADY = 9;
    localparam int ST_ADT = 10;
    localparam int ST2_HOPPER_EMPTY = 0;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [COL_W-1:0] COL_ZERO = 12'h000;

    typedef enum logic [5:0] {
        CMD_NONE = 6'h01,
        CMD_DATA = 6'h02,
        CMD_ST1 = 6'h04,
        CMD_ST2 = 6'h08,
        CMD_FUNC = 6'h10,
        CMD_TEST = 6'h20
    } cmd_t;

    typedef enum logic [1:0] {
        OP_IDLE = 2'h1,
        OP_READ = 2'h2
    } op_state_t;
endpackage

// ==== rtl/cmd_decode_if.sv ====
// Decoded command carried from the decoder to the controller core
`timescale 1ns/1ps
`default_nettype none
interface cmd_decode_if;
    import card_reader_pkg::*;
    logic hit;
    cmd_t cmd;
    logic illegal;
    logic protect_viol;
    modport dec (output hit, output cmd, output illegal, output protect_viol);
    modport ctl (input hit, input cmd, input illegal, input protect_viol);
endinterface
`default_nettype wire

// ==== rtl/command_decoder.sv ====
// Combinational decode of the host command word
`timescale 1ns/1ps
`default_nettype none
module command_decoder
    import card_reader_pkg::*;
(
    cmd_decode_if.dec cif,
    input wire logic instr_read,
    input wire logic [WORD_W-1:0] q_word,
    input wire logic [EQ_W-1:0] equip_code,
    input wire logic protect_jumper,
    input wire logic protect_bit
);
    logic [1:0] code;

    // Bits 2-5 are never looked at; bits 11-15 are the host's to keep zero
    assign code = q_word[CODE_MSB:CODE_LSB]; // RULE_03
    assign cif.hit = (q_word[EQ_MSB:EQ_LSB] == equip_code); // RULE_01

    always_comb begin
        cif.cmd = CMD_NONE;
        if (instr_read) begin
            if (code == CODE_DATA) begin
                cif.cmd = CMD_DATA; // RULE_04
            end else if (code == CODE_ST1) begin
                cif.cmd = CMD_ST1;
            end else if (code == CODE_ST2) begin
                cif.cmd = CMD_ST2;
            end
        end else begin
            if (code == CODE_ST1) begin
                cif.cmd = CMD_FUNC;
            end else if (code == CODE_TEST) begin
                cif.cmd = CMD_TEST;
            end
        end
    end

    assign cif.illegal = (cif.cmd == CMD_NONE); // RULE_04
    // Status reads are exempt so software can always see why it was refused
    assign cif.protect_viol = protect_jumper && !protect_bit
        && (cif.cmd != CMD_ST1) && (cif.cmd != CMD_ST2); // RULE_05
endmodule
`default_nettype wire

// ==== rtl/card_reader_ctrl.sv ====
// Card reader command controller: command execution, status and interrupts
`timescale 1ns/1ps
`default_nettype none
module card_reader_ctrl
    import card_reader_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [EQ_W-1:0] equip_code,
    input wire logic protect_jumper,
    input wire logic instr_valid,
    input wire logic instr_read,
    input wire logic [WORD_W-1:0] q_word,
    input wire logic [WORD_W-1:0] a_write,
    input wire logic protect_bit,
    output logic [WORD_W-1:0] a_read,
    output logic reply,
    output logic ext_reject,
    input wire logic supplies_ok,
    input wire logic hopper_loaded,
    input wire logic stacker_full,
    input wire logic card_jam,
    input wire logic read_alert,
    input wire logic column_ready,
    input wire logic [COL_W-1:0] column_data,
    input wire logic column_81,
    input wire logic reader_fault,
    input wire logic hopper_empty_last,
    output logic feed_start,
    output logic test_mode,
    output logic busy,
    output logic data_irq,
    output logic eop_irq,
    output logic alarm_irq,
    output logic common_irq,
    output logic adt_irq
);
    // ****************************************
    // Decode
    // ****************************************
    cmd_decode_if cif ();

    command_decoder u_dec (
        .cif(cif),
        .instr_read(instr_read),
        .q_word(q_word),
        .equip_code(equip_code),
        .protect_jumper(protect_jumper),
        .protect_bit(protect_bit)
    );

    op_state_t state_r;
    logic [WORD_W-1:0] a_read_r;
    logic [COL_W-1:0] col_buf_r;
    logic reply_r, reject_r, feed_start_r, test_mode_r;
    logic data_r, eop_r, alarm_r, lost_r, adt_mode_r;
    logic data_en_r, eop_en_r, alarm_en_r, eop_resp_r;
    logic ready, addressed, base_ok, cmd_ok, accepted;
    logic data_take, func_go, test_go, clr_ctl, clr_int, feed;
    logic col_ev, lost_set, eop_set, col_load;
    logic [WORD_W-1:0] status_one, status_two;

    function automatic logic fbit(input logic [WORD_W-1:0] w, input int pos);
        return w[pos];
    endfunction

    assign ready = supplies_ok && hopper_loaded && !stacker_full
        && !card_jam && !read_alert; // RULE_17
    assign addressed = instr_valid && cif.hit; // RULE_01
    assign base_ok = !cif.illegal && !cif.protect_viol; // RULE_04 RULE_05

    always_comb begin
        cmd_ok = 1'b1;
        case (cif.cmd)
            CMD_DATA: cmd_ok = ready && data_r && !alarm_r && !lost_r; // RULE_22
            CMD_FUNC: cmd_ok = ready || ((a_write & FN_NOT_READY_MASK) == WORD_ZERO); // RULE_15
            CMD_TEST: cmd_ok = (state_r == OP_IDLE);
            default: cmd_ok = 1'b1;
        endcase
    end

    assign accepted = addressed && base_ok && cmd_ok;
    assign data_take = accepted && (cif.cmd == CMD_DATA);
    assign func_go = accepted && (cif.cmd == CMD_FUNC);
    assign test_go = accepted && (cif.cmd == CMD_TEST);
    // All bits of one word act in the same cycle
    assign clr_ctl = func_go && fbit(a_write, FN_CLEAR); // RULE_14 RULE_06
    assign clr_int = func_go && (fbit(a_write, FN_CLEAR) || fbit(a_write, FN_CLR_INT)); // RULE_07
    assign feed = func_go && fbit(a_write, FN_FEED); // RULE_13

    // ****************************************
    // Card operation
    // ****************************************
    assign col_ev = column_ready && (state_r == OP_READ) && !lost_r && !feed;
    // A column taken in the very cycle the next arrives is not lost
    assign lost_set = col_ev && data_r && !data_take; // RULE_22
    assign col_load = col_ev && !lost_set;
    assign eop_set = ((state_r == OP_READ) && column_81 && !feed && !lost_r)
        || lost_set; // RULE_10 RULE_20

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= OP_IDLE;
        end else begin
            case (state_r)
                OP_IDLE: begin
                    if (feed) begin
                        state_r <= OP_READ; // RULE_13
                    end
                end
                OP_READ: begin
                    if (feed) begin
                        state_r <= OP_READ; // RULE_13
                    end else if (clr_ctl || eop_set) begin
                        state_r <= OP_IDLE; // RULE_06
                    end
                end
                default: state_r <= OP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            feed_start_r <= 1'b0;
        end else begin
            feed_start_r <= feed;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_r <= 1'b0;
            col_buf_r <= COL_ZERO;
        end else begin
            if (col_load) begin
                data_r <= 1'b1; // RULE_19
                col_buf_r <= column_data;
            end else if (data_take || clr_ctl || feed) begin
                data_r <= 1'b0; // RULE_19 RULE_09
            end
        end
    end

    // A new feed wins over a simultaneous end, so the first card gets none
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            eop_r <= 1'b0;
        end else begin
            if (feed) begin
                eop_r <= 1'b0; // RULE_13 RULE_20
            end else if (eop_set) begin
                eop_r <= 1'b1; // RULE_20
            end else if (clr_ctl) begin
                eop_r <= 1'b0; // RULE_20
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lost_r <= 1'b0;
        end else begin
            if (lost_set) begin
                lost_r <= 1'b1; // RULE_22
            end else if (clr_ctl || feed) begin
                lost_r <= 1'b0; // RULE_22
            end
        end
    end

    // Clearing cannot drop an alarm whose malfunction still stands
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            alarm_r <= 1'b0;
        end else begin
            if (lost_set || reader_fault) begin
                alarm_r <= 1'b1; // RULE_21
            end else if (clr_ctl || feed) begin
                alarm_r <= 1'b0; // RULE_21
            end
        end
    end

    // ****************************************
    // Modes and interrupts
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            adt_mode_r <= 1'b0;
            test_mode_r <= 1'b0;
        end else begin
            if (func_go) begin
                adt_mode_r <= fbit(a_write, FN_ADT); // RULE_12
            end
            if (test_go) begin
                test_mode_r <= fbit(a_write, TEST_ON);
            end
        end
    end

    // Enable bits override the clears written beside them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_en_r <= 1'b0;
            eop_en_r <= 1'b0;
            alarm_en_r <= 1'b0;
        end else if (func_go) begin
            data_en_r <= fbit(a_write, FN_DATA_IE) || (data_en_r && !clr_int); // RULE_08
            eop_en_r <= fbit(a_write, FN_EOP_IE) || (eop_en_r && !clr_int); // RULE_10
            alarm_en_r <= fbit(a_write, FN_ALARM_IE) || (alarm_en_r && !clr_int); // RULE_11
        end
    end

    // Only an end seen while enabled raises a response
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            eop_resp_r <= 1'b0;
        end else begin
            if (eop_set && !feed && eop_en_r && !(clr_int && !fbit(a_write, FN_EOP_IE))) begin
                eop_resp_r <= 1'b1; // RULE_10
            end else if (clr_int || feed) begin
                eop_resp_r <= 1'b0; // RULE_10
            end
        end
    end

    assign data_irq = data_en_r && data_r; // RULE_08 RULE_09
    assign eop_irq = eop_resp_r; // RULE_10
    assign alarm_irq = alarm_en_r && alarm_r; // RULE_11
    assign common_irq = data_irq || eop_irq || alarm_irq; // RULE_24
    assign adt_irq = adt_mode_r && data_irq && !eop_irq && !alarm_irq; // RULE_25

    // ****************************************
    // Host replies
    // ****************************************
    always_comb begin
        status_one = WORD_ZERO;
        status_one[ST_READY] = ready; // RULE_16
        status_one[ST_BUSY] = (state_r == OP_READ);
        status_one[ST_INT] = common_irq; // RULE_18
        status_one[ST_DATA] = data_r;
        status_one[ST_EOP] = eop_r;
        status_one[ST_ALARM] = alarm_r;
        status_one[ST_LOST] = lost_r;
        status_one[ST_PROT] = protect_jumper;
        status_one[ST_NREADY] = !ready; // RULE_17
        status_one[ST_ADT] = adt_mode_r;
    end

    always_comb begin
        status_two = WORD_ZERO;
        status_two[ST2_HOPPER_EMPTY] = hopper_empty_last; // RULE_26
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reply_r <= 1'b0;
            reject_r <= 1'b0;
        end else begin
            reply_r <= accepted;
            reject_r <= addressed && !accepted; // RULE_04
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            a_read_r <= WORD_ZERO;
        end else if (accepted) begin
            if (cif.cmd == CMD_ST1) begin
                a_read_r <= status_one; // RULE_16
            end else if (cif.cmd == CMD_ST2) begin
                a_read_r <= status_two; // RULE_26
            end else if (cif.cmd == CMD_DATA) begin
                a_read_r <= {{(WORD_W-COL_W){1'b0}}, col_buf_r}; // RULE_23
            end
        end
    end

    assign a_read = a_read_r;
    assign reply = reply_r;
    assign ext_reject = reject_r;
    assign feed_start = feed_start_r;
    assign test_mode = test_mode_r;
    assign busy = (state_r == OP_READ);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_take;
        addressed && (cif.cmd == CMD_DATA) && accepted;
    endsequence

    sequence s_data_gone;
        !data_r && !data_irq;
    endsequence

    a_status_read_ok: assert property ( // RULE_05
        addressed && ((cif.cmd == CMD_ST1) || (cif.cmd == CMD_ST2)) |=> reply && !ext_reject)
        else $error("status read was not answered");
    a_wrong_equip: assert property ( // RULE_01
        instr_valid && (q_word[EQ_MSB:EQ_LSB] != equip_code) |=> !reply && !ext_reject)
        else $error("answered another equipment code");
    a_take_clears: assert property ( // RULE_19
        s_take ##0 !col_load |=> s_data_gone)
        else $error("data status stayed after transfer");
    a_lost_blocks: assert property ( // RULE_22
        lost_r && addressed && (cif.cmd == CMD_DATA) |=> ext_reject && !reply)
        else $error("transfer accepted after lost data");
    a_lost_eop: assert property ( // RULE_20
        lost_set |=> eop_r && lost_r && alarm_r)
        else $error("lost data did not end operation");
    a_alarm_now: assert property ( // RULE_11
        func_go && fbit(a_write, FN_ALARM_IE) && alarm_r && !clr_ctl && !feed |=> alarm_irq)
        else $error("alarm response not immediate");
    a_adt_hold: assert property ( // RULE_12
        adt_mode_r && !func_go |=> adt_mode_r)
        else $error("auto transfer mode dropped");
    a_not_ready_fn: assert property ( // RULE_15
        addressed && (cif.cmd == CMD_FUNC) && !ready && base_ok
        && fbit(a_write, FN_FEED) |=> ext_reject && !reply && !feed_start)
        else $error("feed accepted while not ready");
    a_common_or: assert property ( // RULE_24
        common_irq == ((data_en_r && data_r) || eop_resp_r || (alarm_en_r && alarm_r)))
        else $error("common interrupt mismatch");
    a_feed_no_eop: assert property ( // RULE_13
        feed |=> !eop_r && !eop_irq && busy)
        else $error("feed left end of operation set");
endmodule
`default_nettype wire

// ==== testbench/host_model.sv ====
// Host processor model issuing equipment-addressed instructions
`timescale 1ns/1ps
`default_nettype none
module host_model
    import card_reader_pkg::*;
(
    input wire logic clock,
    output logic instr_valid,
    output logic instr_read,
    output logic [WORD_W-1:0] q_word,
    output logic [WORD_W-1:0] a_write,
    output logic protect_bit,
    input wire logic [WORD_W-1:0] a_read,
    input wire logic reply,
    input wire logic ext_reject
);
    logic got_reply;
    logic got_reject;
    logic [WORD_W-1:0] got_data;

    initial begin
        instr_valid = 1'b0;
        instr_read = 1'b0;
        q_word = 16'hffff;
        a_write = 16'hffff;
        protect_bit = 1'b0;
    end

    // ****************
    // One instruction
    // ****************
    // Answer is taken in the cycle after the take edge, where it stands
    task automatic issue(input logic rd, input logic [5:0] low, input logic [EQ_W-1:0] eq,
                         input logic [WORD_W-1:0] aw, input logic pb);
        @(posedge clock);
        #1;
        instr_valid = 1'b1;
        instr_read = rd;
        q_word = {5'h00, eq, 1'b0, low};
        a_write = aw;
        protect_bit = pb;
        @(posedge clock);
        #1;
        got_reply = reply;
        got_reject = ext_reject;
        got_data = a_read;
        instr_valid = 1'b0;
        // Released lines change so nothing can lean on stale bits
        q_word = ~q_word;
        a_write = ~a_write;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb_card_reader_ctrl.sv ====
// Self-checking bench for the card reader command controller
`timescale 1ns/1ps
`default_nettype none
module tb_card_reader_ctrl;
    import card_reader_pkg::*;
    localparam logic [EQ_W-1:0] EQ = 4'hb;
    typedef struct packed {
        logic rd;
        logic [5:0] low;
        logic eq_off;
        logic pj;
        logic pb;
        logic rep;
        logic rej;
    } row_t;
    // Read/write, code bits, wrong equipment, jumper, protect bit, reply, reject
    localparam row_t ROWS [13] = '{
        '{1'b1, 6'h01, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
        '{1'b1, 6'h3f, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
        '{1'b1, 6'h02, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
        '{1'b0, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
        '{1'b0, 6'h03, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
        '{1'b0, 6'h02, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
        '{1'b0, 6'h3d, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
        '{1'b1, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
        '{1'b1, 6'h01, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{1'b1, 6'h01, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
        '{1'b1, 6'h03, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
        '{1'b0, 6'h01, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
        '{1'b0, 6'h01, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0}};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic protect_jumper = 1'b0;
    logic supplies_ok = 1'b1;
    logic hopper_loaded = 1'b1;
    logic stacker_full = 1'b0;
    logic card_jam = 1'b0;
    logic read_alert = 1'b0;
    logic column_ready = 1'b0;
    logic [COL_W-1:0] column_data = 12'h000;
    logic column_81 = 1'b0;
    logic reader_fault = 1'b0;
    logic hopper_empty_last = 1'b0;
    logic instr_valid, instr_read, protect_bit, reply, ext_reject, feed_start, test_mode, busy;
    logic data_irq, eop_irq, alarm_irq, common_irq, adt_irq;
    logic [WORD_W-1:0] q_word, a_write, a_read;
    int fails = 0;
    int checks = 0;

    always #50 clock = ~clock;

    card_reader_ctrl u_card_reader_ctrl (.clock(clock), .rst_n(rst_n), .equip_code(EQ),
        .protect_jumper(protect_jumper), .instr_valid(instr_valid), .instr_read(instr_read),
        .q_word(q_word), .a_write(a_write), .protect_bit(protect_bit), .a_read(a_read),
        .reply(reply), .ext_reject(ext_reject), .supplies_ok(supplies_ok),
        .hopper_loaded(hopper_loaded), .stacker_full(stacker_full), .card_jam(card_jam),
        .read_alert(read_alert), .column_ready(column_ready), .column_data(column_data),
        .column_81(column_81), .reader_fault(reader_fault),
        .hopper_empty_last(hopper_empty_last), .feed_start(feed_start),
        .test_mode(test_mode), .busy(busy), .data_irq(data_irq), .eop_irq(eop_irq),
        .alarm_irq(alarm_irq), .common_irq(common_irq), .adt_irq(adt_irq));

    host_model u_host_model (.clock(clock), .instr_valid(instr_valid),
        .instr_read(instr_read), .q_word(q_word), .a_write(a_write),
        .protect_bit(protect_bit), .a_read(a_read), .reply(reply), .ext_reject(ext_reject));

    // ****************
    // Checks and helpers
    // ****************
    task automatic cmp_bit(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic cmp_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test;
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic func(input logic [WORD_W-1:0] aw, input logic rep);
        u_host_model.issue(1'b0, 6'h01, EQ, aw, 1'b1);
        cmp_bit("function reply", rep, u_host_model.got_reply);
    endtask

    task automatic read_word(input logic [1:0] code, input logic [WORD_W-1:0] exp);
        u_host_model.issue(1'b1, {4'h0, code}, EQ, 16'h0000, 1'b1);
        cmp_word("read word", exp, u_host_model.got_data);
    endtask

    // A one-cycle column pulse, or the last column time when last is set
    task automatic col(input logic [COL_W-1:0] d, input logic last);
        @(posedge clock);
        #1;
        column_ready = ~last;
        column_81 = last;
        column_data = d;
        @(posedge clock);
        #1;
        column_ready = 1'b0;
        column_81 = 1'b0;
        column_data = ~d;
    endtask

    // ****************
    // Test sequence
    // ****************
    initial begin
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        cmp_bit("busy", 1'b0, busy);
        foreach (ROWS[i]) begin
            protect_jumper = ROWS[i].pj;
            u_host_model.issue(ROWS[i].rd, ROWS[i].low, ROWS[i].eq_off ? EQ ^ 4'h1 : EQ,
                               16'h0000, ROWS[i].pb);
            cmp_bit("reply", ROWS[i].rep, u_host_model.got_reply);
            cmp_bit("reject", ROWS[i].rej, u_host_model.got_reject);
        end
        read_word(2'h1, 16'h0081);
        protect_jumper = 1'b0;
        func(16'h009c, 1'b1);
        cmp_bit("feed_start", 1'b1, feed_start);
        col(12'ha5c, 1'b0);
        cmp_bit("common_irq", 1'b1, common_irq);
        read_word(2'h1, 16'h000f);
        read_word(2'h0, 16'h0a5c);
        cmp_bit("data_irq", 1'b0, data_irq);
        col(12'h000, 1'b1);
        cmp_bit("eop_irq", 1'b1, eop_irq);
        read_word(2'h1, 16'h0015);
        func(16'h0080, 1'b1);
        read_word(2'h1, 16'h0003);
        col(12'h001, 1'b0);
        col(12'h002, 1'b0);
        cmp_bit("alarm_irq", 1'b1, alarm_irq);
        u_host_model.issue(1'b1, 6'h01, EQ, 16'h0000, 1'b1);
        cmp_word("lost status", 16'h0074, u_host_model.got_data & 16'h0076);
        u_host_model.issue(1'b1, 6'h00, EQ, 16'h0000, 1'b1);
        cmp_bit("lost reject", 1'b1, u_host_model.got_reject);
        reader_fault = 1'b1;
        func(16'h0001, 1'b1);
        read_word(2'h1, 16'h0021);
        func(16'h0010, 1'b1);
        cmp_bit("alarm_irq", 1'b1, alarm_irq);
        reader_fault = 1'b0;
        func(16'h0001, 1'b1);
        read_word(2'h1, 16'h0001);
        func(16'h00c4, 1'b1);
        col(12'h800, 1'b0);
        cmp_bit("adt_irq", 1'b1, adt_irq);
        read_word(2'h1, 16'h040f);
        func(16'h0046, 1'b1);
        cmp_bit("data_irq", 1'b1, data_irq);
        func(16'h0042, 1'b1);
        cmp_bit("adt_irq", 1'b0, adt_irq);
        func(16'h0001, 1'b1);
        read_word(2'h1, 16'h0001);
        func(16'h0088, 1'b1);
        col(12'h004, 1'b0);
        func(16'h0088, 1'b1);
        u_host_model.issue(1'b0, 6'h02, EQ, 16'h0001, 1'b1);
        cmp_bit("test while busy reject", 1'b1, u_host_model.got_reject);
        read_word(2'h1, 16'h0003);
        col(12'h000, 1'b1);
        cmp_bit("eop_irq", 1'b1, eop_irq);
        func(16'h0002, 1'b1);
        func(16'h0008, 1'b1);
        cmp_bit("eop_irq", 1'b0, eop_irq);
        card_jam = 1'b1;
        read_word(2'h1, 16'h0210);
        func(16'h0080, 1'b0);
        func(16'h0003, 1'b1);
        card_jam = 1'b0;
        hopper_empty_last = 1'b1;
        read_word(2'h3, 16'h0001);
        u_host_model.issue(1'b0, 6'h02, EQ, 16'h0001, 1'b1);
        cmp_bit("test_mode", 1'b1, test_mode);
        rst_n = 1'b0;
        @(posedge clock);
        #1;
        rst_n = 1'b1;
        cmp_bit("test_mode", 1'b0, test_mode);
        read_word(2'h1, 16'h0001);
        end_of_test();
    end

    // Whole run is under 120 cycles; this span of 2000 cycles is far beyond it
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
